/* File: design/smk_pkg.sv */
// smk_pkg: constants and carrier types for the security-mode key gate
// assumes: single 50 MHz clock domain, no software-visible registers
package smk_pkg;
   localparam int KEY_W = 16;
   localparam logic [31:0] UNLOCK_KEY_RST = 32'h3672_0414;
   localparam logic [31:0] FULL_KEY_RST   = 32'hFFFF_FFFF;
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 16;

   typedef enum logic [1:0]
   {
      SMK_LOCKED   = 2'b00,
      SMK_UNLOCKED = 2'b01,
      SMK_FULL     = 2'b11
   } smk_mode_t;

   typedef struct packed
   {
      logic                 valid;
      logic                 is_key;
      logic [KEY_W-1:0]     data;
   } smk_cmd_t;

   typedef struct packed
   {
      logic gen_rw;
      logic blk_a_rd;
      logic blk_a_wr;
      logic blk_b_rw;
   } smk_perm_t;
endpackage

/* File: design/smk_key_match.sv */
// smk_key_match: two-word key matcher on the command word stream
// assumes: words arrive one per valid cycle from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module smk_key_match
(
   // clock and reset
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_rst,
   // command word in
   input  wire logic                         i_valid,
   input  wire logic [smk_pkg::KEY_W-1:0]    i_word,
   // stored key
   input  wire logic [31:0]                  i_key,
   // result
   output logic                              o_match
);
   logic pend_r;
   logic pend_nxt;
   logic match_r;
   logic match_nxt;

   // entered word is byte-swapped relative to stored word
   function automatic logic [15:0] swap16(input logic [15:0] w);
      swap16 = {w[7:0], w[15:8]};
   endfunction

   always_comb
   begin
      pend_nxt  = pend_r;
      match_nxt = 1'b0;
      if (i_valid)
      begin
         if (!pend_r)
            pend_nxt = (swap16(i_word) == i_key[smk_pkg::LO_LSB +: 16]);
         else
         begin
            match_nxt = (swap16(i_word) == i_key[smk_pkg::HI_LSB +: 16]);
            pend_nxt  = 1'b0;
            if (!match_nxt)
               pend_nxt = (swap16(i_word) == i_key[smk_pkg::LO_LSB +: 16]);
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pend_r  <= 1'b0;
         match_r <= 1'b0;
      end
      else
      begin
         pend_r  <= pend_nxt;
         match_r <= match_nxt;
      end
   end

   assign o_match = match_r;
endmodule
`default_nettype wire

/* File: design/smk_gate.sv */
// smk_gate: security-mode gate for the nonvolatile parameter store
// assumes: command writes and key updates come from same-clock logic
//
// Summary of operation
// - mode advances only on its own key pair, returns to locked on relock
// - locked flag set while locked, cleared on unlock
// - full access flag cleared on full key
// - keys stored as two words, word 0 first
// - entered words are byte swapped
// - key updates accepted only in full access
// - access permissions follow the mode
`timescale 1ns/10ps
`default_nettype none
module smk_gate
(
   // clock and reset
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rst,
   // control command port
   input  wire smk_pkg::smk_cmd_t           i_cmd,
   input  wire logic                        i_relock,
   // key update request
   input  wire logic                        i_key_wr,
   input  wire logic                        i_key_sel_full,
   input  wire logic [31:0]                 i_key_data,
   // status and permissions
   output logic                             o_locked_flag,
   output logic                             o_full_access_state_flag,
   output smk_pkg::smk_mode_t               o_mode,
   output smk_pkg::smk_perm_t               o_perm,
   output logic                             o_key_wr_ack,
   output logic                             o_key_wr_nak
);
   // mode state
   smk_pkg::smk_mode_t mode_r;
   smk_pkg::smk_mode_t mode_nxt;

   // stored keys and update responses
   logic [31:0]        ukey_r;
   logic [31:0]        ukey_nxt;
   logic [31:0]        fkey_r;
   logic [31:0]        fkey_nxt;
   logic               ack_r;
   logic               ack_nxt;
   logic               nak_r;
   logic               nak_nxt;

   // status word and permissions
   logic               lk_r;
   logic               lk_nxt;
   logic               fa_r;
   logic               fa_nxt;
   smk_pkg::smk_perm_t perm_r;
   smk_pkg::smk_perm_t perm_nxt;

   // matcher hookup, index 0 unlock, index 1 full access
   logic               key_word;
   wire  [1:0]         hit;
   logic               unl_hit;
   logic               full_hit;

   // mode decodes shared by status and key gate
   function automatic logic is_locked(input smk_pkg::smk_mode_t m);
      is_locked = (m == smk_pkg::SMK_LOCKED);
   endfunction

   function automatic logic is_full(input smk_pkg::smk_mode_t m);
      is_full = (m == smk_pkg::SMK_FULL);
   endfunction

   // access rights per mode
   function automatic smk_pkg::smk_perm_t perm_of(input smk_pkg::smk_mode_t m);
      perm_of.gen_rw   = !is_locked(m);
      perm_of.blk_a_rd = 1'b1;
      perm_of.blk_a_wr = !is_locked(m);
      perm_of.blk_b_rw = 1'b1;
   endfunction

   // every valid write is a key candidate, so other writes break a pair
   assign key_word = i_cmd.valid;
   assign unl_hit  = hit[0];
   assign full_hit = hit[1];

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_match
         smk_key_match u_match
         (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .i_valid   (key_word),
            .i_word    (i_cmd.data),
            .i_key     ((g == 0) ? ukey_r : fkey_r),
            .o_match   (hit[g])
         );
      end
   endgenerate

   // mode transitions; each mode honours only its own next key
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         smk_pkg::SMK_LOCKED:
         begin
            if (unl_hit)
               mode_nxt = smk_pkg::SMK_UNLOCKED;
         end
         smk_pkg::SMK_UNLOCKED:
         begin
            if (i_relock)
               mode_nxt = smk_pkg::SMK_LOCKED;
            else if (full_hit)
               mode_nxt = smk_pkg::SMK_FULL;
         end
         smk_pkg::SMK_FULL:
         begin
            if (i_relock)
               mode_nxt = smk_pkg::SMK_LOCKED;
         end
         default:
            mode_nxt = smk_pkg::SMK_LOCKED;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         mode_r <= smk_pkg::SMK_LOCKED;
      else
         mode_r <= mode_nxt;
   end

   // key store rewrite, open only in full access
   always_comb
   begin
      ukey_nxt = ukey_r;
      fkey_nxt = fkey_r;
      if (i_key_wr && is_full(mode_r))
      begin
         if (i_key_sel_full)
            fkey_nxt = i_key_data;
         else
            ukey_nxt = i_key_data;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ukey_r <= smk_pkg::UNLOCK_KEY_RST;
         fkey_r <= smk_pkg::FULL_KEY_RST;
      end
      else
      begin
         ukey_r <= ukey_nxt;
         fkey_r <= fkey_nxt;
      end
   end

   // one-cycle answer to every update request
   always_comb
   begin
      ack_nxt = 1'b0;
      nak_nxt = 1'b0;
      if (i_key_wr)
      begin
         if (is_full(mode_r))
            ack_nxt = 1'b1;
         else
            nak_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack_r <= 1'b0;
         nak_r <= 1'b0;
      end
      else
      begin
         ack_r <= ack_nxt;
         nak_r <= nak_nxt;
      end
   end

   // status follows the next mode so it changes together with o_mode
   always_comb
   begin
      lk_nxt   = is_locked(mode_nxt);
      fa_nxt   = !is_full(mode_nxt);
      perm_nxt = perm_of(mode_nxt);
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lk_r   <= 1'b1;
         fa_r   <= 1'b1;
         perm_r <= smk_pkg::smk_perm_t'(4'h5);
      end
      else
      begin
         lk_r   <= lk_nxt;
         fa_r   <= fa_nxt;
         perm_r <= perm_nxt;
      end
   end

   assign o_mode                   = mode_r;
   assign o_locked_flag            = lk_r;
   assign o_full_access_state_flag = fa_r;
   assign o_perm                   = perm_r;
   assign o_key_wr_ack             = ack_r;
   assign o_key_wr_nak             = nak_r;
endmodule
`default_nettype wire

/* File: verification/smk_gate_checker.sv */
// smk_gate_checker: port assertions for the key gate
// assumes: bound to smk_gate, one clock domain
`timescale 1ns/10ps
`default_nettype none
module smk_gate_checker
(
   // watched ports
   input wire logic               i_sys_clk,
   input wire logic               i_rst,
   input wire smk_pkg::smk_cmd_t  i_cmd,
   input wire logic               i_relock,
   input wire logic               i_key_wr,
   input wire logic               o_locked_flag,
   input wire logic               o_full_access_state_flag,
   input wire smk_pkg::smk_mode_t o_mode,
   input wire smk_pkg::smk_perm_t o_perm,
   input wire logic               o_key_wr_ack,
   input wire logic               o_key_wr_nak
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire lk = o_mode == smk_pkg::SMK_LOCKED;
   wire fl = o_mode == smk_pkg::SMK_FULL;
   property p_lk; o_locked_flag == lk; endproperty
   a_lk: assert property (p_lk) else $error("locked flag");
   property p_fa; o_full_access_state_flag == !fl; endproperty
   a_fa: assert property (p_fa) else $error("full flag");
   property p_pm; o_perm == (lk ? 4'h5 : 4'hF); endproperty
   a_pm: assert property (p_pm) else $error("perm");
   property p_ch; $changed(o_mode) && !lk |-> $past(i_cmd.valid, 2); endproperty
   a_ch: assert property (p_ch) else $error("mode change");
   property p_up; lk |=> !fl; endproperty
   a_up: assert property (p_up) else $error("skip");
   property p_kw; i_key_wr |=> o_key_wr_ack == $past(fl) && o_key_wr_nak != $past(fl); endproperty
   a_kw: assert property (p_kw) else $error("key update");
   property p_rs; o_key_wr_ack || o_key_wr_nak |-> $past(i_key_wr); endproperty
   a_rs: assert property (p_rs) else $error("stray ack");
   property p_rl; i_relock |-> ##[1:4] lk; endproperty
   a_rl: assert property (p_rl) else $error("relock");
   c_u: cover property (!lk && !fl);
   c_f: cover property (fl);
   c_n: cover property (o_key_wr_nak);
   c_a: cover property (o_key_wr_ack);
endmodule
bind smk_gate smk_gate_checker chk
(
   .i_sys_clk                (i_sys_clk),
   .i_rst                    (i_rst),
   .i_cmd                    (i_cmd),
   .i_relock                 (i_relock),
   .i_key_wr                 (i_key_wr),
   .o_locked_flag            (o_locked_flag),
   .o_full_access_state_flag (o_full_access_state_flag),
   .o_mode                   (o_mode),
   .o_perm                   (o_perm),
   .o_key_wr_ack             (o_key_wr_ack),
   .o_key_wr_nak             (o_key_wr_nak)
);
`default_nettype wire

/* File: verification/smk_host_model.sv */
// smk_host_model: host writing words to the command port
// assumes: bench calls its tasks; drives on falling edge
`timescale 1ns/10ps
`default_nettype none
module smk_host_model
(
   // clock
   input  wire logic              i_sys_clk,
   // command port
   output var  smk_pkg::smk_cmd_t o_cmd
);
   initial o_cmd = '0;
   task word(input logic [15:0] w);
      @(negedge i_sys_clk);
      o_cmd = {2'b11, w};
   endtask
   task idle;
      @(negedge i_sys_clk);
      o_cmd = {2'b00, ~o_cmd.data};
   endtask
   task key_pair(input logic [31:0] k);
      word({k[7:0], k[15:8]});
      word({k[23:16], k[31:24]});
      idle;
   endtask
endmodule
`default_nettype wire

/* File: verification/security_mode_key_unlock_bench.sv */
// bench: key gate driven by the host model
// assumes: 50 MHz clock, reset held 5 cycles
`timescale 1ns/10ps
`default_nettype none
module security_mode_key_unlock_bench;
   logic               clk        = 1'b0;
   logic               rst        = 1'b1;
   logic               rlk        = 1'b0;
   logic               kwr        = 1'b0;
   logic               ksel       = 1'b0;
   logic [31:0]        kdat       = 32'h0000_0000;
   smk_pkg::smk_cmd_t  cmd;
   logic               lf;
   logic               full_access_state_flag;
   logic               ack;
   logic               nak;
   smk_pkg::smk_mode_t mode;
   smk_pkg::smk_perm_t perm;
   int                 mismatches = 0;
   int                 cmp_count  = 0;
   int                 cyc        = 0;
   always #10 clk = ~clk;
   smk_host_model host (.i_sys_clk(clk), .o_cmd(cmd));
   smk_gate dut (.i_sys_clk(clk), .i_rst(rst), .i_cmd(cmd), .i_relock(rlk), .i_key_wr(kwr),
      .i_key_sel_full(ksel), .i_key_data(kdat), .o_locked_flag(lf), .o_full_access_state_flag(full_access_state_flag),
      .o_mode(mode), .o_perm(perm), .o_key_wr_ack(ack), .o_key_wr_nak(nak));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task see(input logic [1:0] m);
      repeat (3) @(negedge clk);
      chk({perm, mode, lf, full_access_state_flag}, {(m == 2'h0) ? 4'h5 : 4'hF, m, m == 2'h0, m != 2'h3});
   endtask
   task kw(input logic full, input logic [31:0] d, input logic a);
      @(negedge clk);
      kwr = 1'b1;
      ksel = full;
      kdat = d;
      @(negedge clk);
      kwr = 1'b0;
      chk({6'h00, ack, nak}, {6'h00, a, !a});
      @(negedge clk);
      chk({6'h00, ack, nak}, 8'h00);
   endtask
   task relock;
      @(negedge clk);
      rlk = 1'b1;
      @(negedge clk);
      rlk = 1'b0;
   endtask
   task t_reset_state;
      see(2'h0);
      $display("test reset_state done");
   endtask
   task t_refusals;
      host.key_pair(32'h1234_5678);
      see(2'h0);
      host.key_pair(smk_pkg::FULL_KEY_RST);
      see(2'h0);
      kw(1'b0, 32'h5678_1234, 1'b0);
      host.word(16'h1404);
      host.word(16'hABCD);
      host.word(16'h7236);
      host.idle;
      see(2'h0);
      $display("test refusals done");
   endtask
   task t_unlock_full;
      host.key_pair(smk_pkg::UNLOCK_KEY_RST);
      see(2'h1);
      kw(1'b1, 32'h0000_0000, 1'b0);
      relock;
      see(2'h0);
      host.key_pair(smk_pkg::UNLOCK_KEY_RST);
      see(2'h1);
      host.key_pair(smk_pkg::FULL_KEY_RST);
      see(2'h3);
      $display("test unlock_full done");
   endtask
   task t_key_update;
      kw(1'b0, 32'h5678_1234, 1'b1);
      kw(1'b1, 32'hA5C3_5A3C, 1'b1);
      relock;
      see(2'h0);
      host.key_pair(smk_pkg::UNLOCK_KEY_RST);
      see(2'h0);
      host.key_pair(32'h5678_1234);
      see(2'h1);
      host.key_pair(smk_pkg::FULL_KEY_RST);
      see(2'h1);
      host.key_pair(32'hA5C3_5A3C);
      see(2'h3);
      $display("test key_update done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 400)
      begin
         mismatches++;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_reset_state;
      t_refusals;
      t_unlock_full;
      t_key_update;
      report_and_stop;
   end
endmodule
`default_nettype wire
